// *** pkg/wpr_pkg.sv ***
// Purpose: shared constants and types of the wiper position register block
// Assumes: one 7-bit wiper register, 128 taps, byte framing of 8 bits plus ack
// Notes:   the phase type is driven by the two-wire protocol engine outside
package wpr_pkg;

  // wiper register and tap array
  localparam int          WPR_WIPER_W     = 7;
  localparam int          WPR_TAP_COUNT   = 128;
  localparam logic [6:0]  WPR_WIPER_RESET = 7'h40;   // midscale after power-up
  localparam logic [6:0]  WPR_WIPER_LOW   = 7'h00;   // tap nearest the low terminal
  localparam logic [6:0]  WPR_WIPER_HIGH  = 7'h7f;   // tap nearest the high terminal

  // register address that reaches the wiper register
  localparam logic [7:0]  WPR_ADDR_WIPER  = 8'h00;

  // bit slots inside one byte frame, counted in serial clock falling edges
  localparam logic [3:0]  WPR_SLOT_FIRST  = 4'h0;
  localparam logic [3:0]  WPR_SLOT_LSB    = 4'h7;    // slot of the eighth data bit
  localparam logic [3:0]  WPR_SLOT_ACK    = 4'h8;    // ninth clock, acknowledge
  localparam logic [3:0]  WPR_SLOT_STEP   = 4'h1;

  // reset values of the serial side
  localparam logic [7:0]  WPR_SHIFT_RESET = 8'h00;
  localparam logic        WPR_SDA_LOW     = 1'b0;    // open-drain pin only pulls low

  // kind of byte the protocol engine says is on the wire
  typedef enum logic [3:0] {
    WPR_PH_IDLE  = 4'b0001,
    WPR_PH_ADDR  = 4'b0010,
    WPR_PH_WDATA = 4'b0100,
    WPR_PH_RDATA = 4'b1000
  } wpr_phase_type;

  // read transmitter state
  typedef enum logic [1:0] {
    WPR_RD_SEND = 2'b01,
    WPR_RD_HALT = 2'b10
  } wpr_rd_type;

endpackage

// *** pkg/wpr_tap_if.sv ***
// Purpose: carries the wiper code to the tap decoder and its selects back
// Assumes: one clock domain
// Notes:   the select vector is registered inside the decoder
`timescale 1ns/1ns
`default_nettype none
interface wpr_tap_if;
  import wpr_pkg::*;

  logic [WPR_WIPER_W-1:0]   code;
  logic [WPR_TAP_COUNT-1:0] sel;

  modport ctrl (output code, input sel);
  modport dec  (input code, output sel);
endinterface
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the wiper position register
// Assumes: bench plays the protocol engine through the phase input
// Notes:   sda has a pull-up, so a released line reads 1
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wpr_pkg::*;
  logic          i_clk, i_rst, scl, hsda, sda_o, sda_oe, addr_ok, wr_stb, rd_halt;
  wpr_phase_type phase;
  logic [6:0]    wiper;
  logic [127:0]  tap;
  int            err_total, num_checks;
  int            strobes;
  // open-drain wire with pull-up: the device pin value counts only while enabled
  wire logic     sda = hsda & (sda_oe ? sda_o : 1'b1);

  wpr_host host_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  wpr_wiper_reg dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_phase(phase), .o_addr_ok(addr_ok),
    .o_wr_strobe(wr_stb), .o_rd_halted(rd_halt), .o_wiper(wiper), .o_tap_sel(tap));

  // count write strobes, so stores and refusals are judged by number
  always @(posedge i_clk) begin
    if (wr_stb === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(wpr_phase_type p, logic [8:0] tx, output logic [8:0] rx);
    phase <= p;
    host_u.byte_io(tx, rx);
  endtask

  task automatic t_write(logic [7:0] d);
    logic [8:0] rx;
    int         s0;
    s0 = strobes;
    xfer(WPR_PH_ADDR, {WPR_ADDR_WIPER, 1'b1}, rx);
    check("addr ack", 1'b0, rx[0]);
    check("addr ok", 1'b1, addr_ok);
    xfer(WPR_PH_WDATA, {d, 1'b1}, rx);
    check("data ack", 1'b0, rx[0]);
    check("wiper", d[6:0], wiper);
    check("write strobes", s0 + 1, strobes);
    check("tap", 128'h1 << d[6:0], tap);
    $display("test write %h done", d);
  endtask

  // nonzero address: no ack, data dropped
  task automatic t_bad_addr();
    logic [8:0] rx;
    int         s0;
    s0 = strobes;
    xfer(WPR_PH_ADDR, 9'h003, rx);
    check("addr nack", 1'b1, rx[0]);
    check("addr refused", 1'b0, addr_ok);
    xfer(WPR_PH_WDATA, 9'h0e1, rx);
    check("data nack", 1'b1, rx[0]);
    check("wiper kept", 7'h25, wiper);
    check("no strobe", s0, strobes);
    $display("test bad address done");
  endtask

  // repeated read while the host acks, then a no-ack
  task automatic t_read();
    logic [8:0] rx;
    xfer(WPR_PH_ADDR, 9'h001, rx);
    check("read addr ack", 1'b0, rx[0]);
    repeat (2) begin
      xfer(WPR_PH_RDATA, 9'h1fe, rx);
      check("read byte", {1'b0, 7'h25, 1'b0}, rx);
      check("read running", 1'b0, rd_halt);
    end
    xfer(WPR_PH_RDATA, 9'h1ff, rx);
    check("last byte", {1'b0, 7'h25, 1'b1}, rx);
    check("read halt", 1'b1, rd_halt);
    xfer(WPR_PH_IDLE, 9'h1ff, rx);
    $display("test read done");
  endtask

  // reset in mid-run: wiper back to midscale, accepted address forgotten
  task automatic t_reset();
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("rerun wiper", WPR_WIPER_RESET, wiper);
    check("rerun addr ok", 1'b0, addr_ok);
    @(posedge i_clk);
    check("rerun tap", 128'h1 << 64, tap);
    $display("test mid-run reset done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [8:0] rx;
    i_rst = 1'b1;
    phase = WPR_PH_IDLE;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("reset wiper", WPR_WIPER_RESET, wiper);
    check("reset tap", 128'h1 << 64, tap);
    xfer(WPR_PH_IDLE, 9'h1ff, rx);
    t_write(8'h00);
    t_write(8'hff);
    t_write(8'h25);
    t_bad_addr();
    t_read();
    t_reset();
    print_verdict();
  end

  // hang guard, several times the expected run
  initial begin
    repeat (6000) @(posedge i_clk);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire

// *** tb/wpr_host.sv ***
// Purpose: two-wire host that clocks bytes in and out
// Assumes: sda is the resolved wire with a pull-up
// Notes:   scl phases of 4 cycles each, above the 3-cycle minimum
`timescale 1ns/1ns
`default_nettype none
module wpr_host (
  // clock
  input  wire logic i_clk,
  // resolved data line
  input  wire logic i_sda,
  // host pins
  output logic      o_scl,
  output logic      o_sda
);
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // nine pulses, msb first; the ninth bit is the host ack or a release
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_scl <= 1'b0;
      o_sda <= tx[i];
      repeat (4) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
      rx[i] = i_sda;
    end
    o_scl <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** tb/wpr_wiper_reg_asserts.sv ***
// Purpose: port-level checks of the wiper register block
// Assumes: one clock, async active-high reset
// Notes:   bound onto every wpr_wiper_reg instance
`timescale 1ns/1ns
`default_nettype none
module wpr_chk
  import wpr_pkg::*;
(
  // clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  // watched ports
  input wire logic                     i_scl,
  input wire wpr_phase_type            i_phase,
  input wire logic                     o_sda,
  input wire logic                     o_sda_oe,
  input wire logic                     o_addr_ok,
  input wire logic                     o_wr_strobe,
  input wire logic                     o_rd_halted,
  input wire logic [WPR_WIPER_W-1:0]   o_wiper,
  input wire logic [WPR_TAP_COUNT-1:0] o_tap_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // tap selects track the code one cycle later, one switch at a time
  a_tap_onehot: assert property ($onehot(o_tap_sel))
    else $error("tap select not one-hot");
  a_tap_follow: assert property (o_tap_sel == (128'h1 << $past(o_wiper)))
    else $error("tap select does not follow wiper");
  // the wiper moves only by a strobed write of an accepted address
  a_load_strobe: assert property ($changed(o_wiper) |-> o_wr_strobe)
    else $error("wiper changed without strobe");
  a_strobe_pulse: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe longer than one cycle");
  a_strobe_addr: assert property (o_wr_strobe |-> o_addr_ok && i_phase == WPR_PH_WDATA)
    else $error("write without accepted address");
  // open drain: only pulls low, and only moves while the clock is low
  a_sda_low: assert property (o_sda == WPR_SDA_LOW)
    else $error("sda output not low");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda moved while scl high");
  a_halt_free: assert property (o_rd_halted |-> !o_sda_oe)
    else $error("sda driven after host no-ack");
  // main scenarios reached
  c_write: cover property (o_wr_strobe);
  c_halt: cover property (o_rd_halted);
  c_addr: cover property ($rose(o_addr_ok));
endmodule
bind wpr_wiper_reg wpr_chk chk_u (.i_clk, .i_rst, .i_scl, .i_phase, .o_sda, .o_sda_oe,
  .o_addr_ok, .o_wr_strobe, .o_rd_halted, .o_wiper, .o_tap_sel);
`default_nettype wire

// *** verilog/wpr_tap_decoder.sv ***
// Purpose: one-hot decode of the wiper code onto the tap switches
// Assumes: code is a registered value
// Notes:   registered so switch gates never see decode glitches
`timescale 1ns/1ns
`default_nettype none
module wpr_tap_decoder
  import wpr_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // code in, selects out
  wpr_tap_if.dec    tap
);

  // exactly one select high; code n closes switch n, code 0 is the low end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tap.sel <= {{(WPR_TAP_COUNT-1){1'b0}}, 1'b1} << WPR_WIPER_RESET;
    end else begin
      tap.sel <= {{(WPR_TAP_COUNT-1){1'b0}}, 1'b1} << tap.code;
    end
  end

endmodule
`default_nettype wire

// *** verilog/wpr_wiper_reg.sv ***
// Purpose: wiper position register with its serial byte shifter and tap decode
// Assumes: scl and sda are already synchronous; the protocol engine outside
//          detects start/stop, checks the identification byte and tells this
//          block through i_phase which byte comes next
// Notes:   i_phase must go to its new value only while scl is low, after the
//          falling edge that ends the previous ack slot
`timescale 1ns/1ns
`default_nettype none
module wpr_wiper_reg
  import wpr_pkg::*;
(
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // two-wire pins, open drain
  input  wire logic                     i_scl,
  input  wire logic                     i_sda,
  output logic                          o_sda,
  output logic                          o_sda_oe,
  // from the protocol engine
  input  wire wpr_phase_type            i_phase,
  // status toward the protocol engine
  output logic                          o_addr_ok,
  output logic                          o_wr_strobe,
  output logic                          o_rd_halted,
  // analog side
  output logic [WPR_WIPER_W-1:0]        o_wiper,
  output logic [WPR_TAP_COUNT-1:0]      o_tap_sel
);

  logic                   scl_r;
  logic                   scl_rise;
  logic                   scl_fall;
  logic [3:0]             slot_r;
  logic [7:0]             shift_r;
  logic [7:0]             rd_byte;
  logic                   addr_ok_r;
  logic [WPR_WIPER_W-1:0] wiper_r;
  logic                   wr_strobe_r;
  wpr_rd_type             rd_state_r;
  logic                   rd_halted_r;
  logic                   sda_oe_r;
  logic                   sda_oe_nxt;
  logic                   sda_r;
  logic                   byte_active;

  wpr_tap_if tap ();

  // serial clock edge detect; scl is taken as already synchronous
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_r <= 1'b1;
    end else begin
      scl_r <= i_scl;
    end
  end

  assign scl_rise = i_scl & ~scl_r;
  assign scl_fall = ~i_scl & scl_r;

  // a byte frame exists only while the engine names a byte kind
  always_comb begin
    byte_active = 1'b1;
    unique case (i_phase)
      WPR_PH_IDLE:  byte_active = 1'b0;
      WPR_PH_ADDR:  byte_active = 1'b1;
      WPR_PH_WDATA: byte_active = 1'b1;
      WPR_PH_RDATA: byte_active = 1'b1;
      default:      byte_active = 1'b0;  // illegal code from outside is treated as idle
    endcase
  end

  // slot counter: eight data slots then the ack slot, advanced on scl falls
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_r <= WPR_SLOT_FIRST;
    end else if (!byte_active) begin
      slot_r <= WPR_SLOT_FIRST;
    end else if (scl_fall) begin
      if (slot_r == WPR_SLOT_ACK) begin
        slot_r <= WPR_SLOT_FIRST;
      end else begin
        slot_r <= slot_r + WPR_SLOT_STEP;
      end
    end
  end

  // receive shifter, first bit lands in bit 7
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_r <= WPR_SHIFT_RESET;
    end else if (byte_active && scl_rise && slot_r != WPR_SLOT_ACK) begin
      shift_r <= {shift_r[6:0], i_sda};
    end
  end

  // address check at the fall that ends the address byte; kept for a later read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_ok_r <= 1'b0;
    end else if (i_phase == WPR_PH_ADDR && scl_fall && slot_r == WPR_SLOT_LSB) begin
      addr_ok_r <= (shift_r == WPR_ADDR_WIPER);
    end
  end

  // wiper register: loaded on the fall of the data byte's last bit; the top
  // bit of the data byte has no storage and is dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wiper_r     <= WPR_WIPER_RESET;
      wr_strobe_r <= 1'b0;
    end else begin
      wr_strobe_r <= 1'b0;
      if (i_phase == WPR_PH_WDATA && scl_fall && slot_r == WPR_SLOT_LSB && addr_ok_r) begin
        wiper_r     <= shift_r[WPR_WIPER_W-1:0];
        wr_strobe_r <= 1'b1;
      end
    end
  end

  // byte sent in a read: the register sits in the low bits, bit 7 reads zero
  assign rd_byte = {1'b0, wiper_r};

  // read transmitter: a no-ack from the host halts it until the phase ends;
  // the halted flag is its own flop so the status port needs no decode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_state_r  <= WPR_RD_SEND;
      rd_halted_r <= 1'b0;
    end else if (i_phase != WPR_PH_RDATA) begin
      rd_state_r  <= WPR_RD_SEND;
      rd_halted_r <= 1'b0;
    end else begin
      unique case (rd_state_r)
        WPR_RD_SEND: begin
          if (scl_rise && slot_r == WPR_SLOT_ACK && i_sda) begin
            rd_state_r  <= WPR_RD_HALT;
            rd_halted_r <= 1'b1;
          end
        end
        WPR_RD_HALT: begin
          rd_state_r  <= WPR_RD_HALT;
          rd_halted_r <= 1'b1;
        end
        default: begin
          rd_state_r  <= WPR_RD_SEND;
          rd_halted_r <= 1'b0;
        end
      endcase
    end
  end

  // pin drive: ack slots after a good address or write, data bits in a read.
  // the pin is only ever pulled low, so a one is sent by releasing it
  always_comb begin
    sda_oe_nxt = 1'b0;
    unique case (i_phase)
      WPR_PH_IDLE: begin
        sda_oe_nxt = 1'b0;
      end
      WPR_PH_ADDR: begin
        sda_oe_nxt = (slot_r == WPR_SLOT_ACK) && (shift_r == WPR_ADDR_WIPER) && addr_ok_r;
      end
      WPR_PH_WDATA: begin
        sda_oe_nxt = (slot_r == WPR_SLOT_ACK) && addr_ok_r;
      end
      WPR_PH_RDATA: begin
        if (slot_r != WPR_SLOT_ACK && rd_state_r == WPR_RD_SEND && addr_ok_r) begin
          sda_oe_nxt = ~rd_byte[3'(WPR_SLOT_LSB - slot_r)];
        end
      end
      default: begin
        sda_oe_nxt = 1'b0;
      end
    endcase
  end

  // registered drive: two system clocks behind the scl fall, far inside scl low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_oe_r <= 1'b0;
      sda_r    <= WPR_SDA_LOW;
    end else begin
      sda_oe_r <= sda_oe_nxt;
      sda_r    <= WPR_SDA_LOW;
    end
  end

  assign tap.code = wiper_r;

  // one-hot tap decode
  wpr_tap_decoder u_dec (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .tap   (tap)
  );

  // outputs
  assign o_sda       = sda_r;
  assign o_sda_oe    = sda_oe_r;
  assign o_addr_ok   = addr_ok_r;
  assign o_wr_strobe = wr_strobe_r;
  assign o_rd_halted = rd_halted_r;
  assign o_wiper     = wiper_r;
  assign o_tap_sel   = tap.sel;

endmodule
`default_nettype wire
